//--- verilog/vls_pkg.sv
// Shared constants, types and helpers for the serial video link
package vls_pkg;
  // Clock and timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned STOP_FREQ_KHZ = 3000;
  localparam int unsigned STOP_CYC =
    (CLK_MHZ * 1000 + STOP_FREQ_KHZ - 1) / STOP_FREQ_KHZ;
  localparam int unsigned LOCK_EDGES = 4;
  localparam int unsigned FILT_MIN = 3;
  localparam int unsigned CTL_WINDOW = 130;
  localparam int unsigned SSC_MOD_KHZ = 35;
  localparam int unsigned SSC_DEV_PCT = 2;
  localparam int unsigned PCLK_DIV = 32;
  localparam int unsigned PCLK_HALF = PCLK_DIV / 2;
  localparam int unsigned GAP_CYC = 64;
  // Parallel word layout
  localparam int unsigned WORD_W = 28;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned CTL_W = 3;
  localparam int unsigned BIT_HS = 24;
  localparam int unsigned BIT_VS = 25;
  localparam int unsigned BIT_DE = 26;
  localparam int unsigned BIT_UNUSED = 27;
  // Serial frame layout, bit 0 sent first
  localparam int unsigned FRAME_W = 28;
  localparam int unsigned FR_CLK_HI = 0;
  localparam int unsigned FR_CLK_LO = 1;
  localparam int unsigned FR_DATA = 2;
  localparam int unsigned FR_CHECK = 26;
  localparam int unsigned FR_BAL = 27;
  // Coding
  localparam int unsigned SHUF_MUL = 7;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  // Driver settings
  localparam int unsigned SWING_HIGH_MVPP = 840;
  localparam int unsigned SWING_STD_MVPP = 560;
  localparam logic [2:0] EMPH_OFF = 3'h0;
  localparam logic [2:0] EMPH_3DB = 3'h1;
  localparam logic [2:0] EMPH_6DB = 3'h2;
  localparam logic [2:0] EMPH_9DB = 3'h3;
  localparam logic [2:0] EMPH_12DB = 3'h4;
  localparam logic [1:0] MODE_FILT_OFF = 2'h0;
  localparam logic [1:0] MODE_FILT_ON = 2'h1;
  // Register map
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam int unsigned CTRL_SWING = 0;
  localparam int unsigned CTRL_SWING_SRC = 1;
  localparam int unsigned CTRL_FILT = 2;
  localparam int unsigned CTRL_FILT_SRC = 3;
  localparam int unsigned CTRL_EMPH_LSB = 4;
  localparam int unsigned CTRL_EMPH_SRC = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned STAT_SLEEP = 0;
  localparam int unsigned STAT_RUN = 1;

  typedef enum logic [1:0] {ST_SLEEP, ST_LOCK, ST_RUN} vls_state_t;

  // One step of the scrambler sequence
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = s[0] ? ((s >> 1) ^ LFSR_TAPS) : (s >> 1);
  endfunction : lfsr_next

  // Scrambler key for one frame
  function automatic logic [23:0] scr_key(input logic [15:0] s);
    scr_key = {s[7:0], s};
  endfunction : scr_key
endpackage : vls_pkg

//--- verilog/vls_link_if.sv
// Link between the host-side end and the serializer
interface vls_link_if;
  logic pclk;
  logic [vls_pkg::WORD_W-1:0] pword;
  logic power_down_bar;
  logic [1:0] compat_mode;
  logic output_swing_select;
  logic [2:0] tx_emphasis_level;
  logic serial_p;
  logic serial_n;
  logic swing_high;
  logic [2:0] emph_now;

  modport ser (
    input pclk, pword, power_down_bar, compat_mode,
    input output_swing_select, tx_emphasis_level,
    output serial_p, serial_n, swing_high, emph_now
  );
  modport host (
    output pclk, pword, power_down_bar, compat_mode,
    output output_swing_select, tx_emphasis_level,
    input serial_p, serial_n, swing_high, emph_now
  );
endinterface : vls_link_if

//--- verilog/vls_serializer.sv
// Serializer end: sample, filter, scramble, balance, shuffle, send
//
// Summary of operation
// (R1) Controls: DE bit 26, HS 24, VS 25
// (R2) Filter on: DE/HS two edges, 3-clock pulses
// (R3) Filter off: two edges per 130, any width
// (R4) VS: one edge per 130, 130-clock pulses
// (R5) Filter drops short glitches on control bits
// (R6) Encode: scramble, then balance, then shuffle
// (R7) Pixel clock may carry 35 kHz, 2% spread
// (R8) Swing select high 840, low 560 mVp-p
// (R9) Emphasis cuts drive one bit after edges
// (R10) Host sets high swing whenever emphasis used
// (R11) Power down: link off, 0V, registers reset
// (R12) Sleep when pixel clock below 3 MHz
// (R13) Host parks stopped pixel clock at static level
// (R14) After restart lock first, then send pixels
// (R15) Sleep keeps register contents
// (R16) Mode 00 filter off, 01 on, or register
// (R17) Frame: 1, 0, 24 data, check, balance
// (R18) Sample 27 of 28 bits, ignore 28th
// (R19) Same scrambler, balance, shuffle on both ends
// (R20) Per-signal counter rejects sub-3-clock changes
module vls_serializer (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Link pins
  vls_link_if.ser link,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  localparam logic [7:0] STOP_CNT = 8'(vls_pkg::STOP_CYC);
  localparam logic [2:0] LOCK_LAST = 3'(vls_pkg::LOCK_EDGES - 1);
  localparam logic [1:0] FILT_LAST = 2'(vls_pkg::FILT_MIN - 1);
  localparam logic [4:0] FRAME_BITS = 5'(vls_pkg::FRAME_W);

  logic clr;
  logic [2:0] pclk_s_q, pclk_s_d;
  logic pclk_lvl_q, pclk_lvl_d;
  logic rise;
  logic [7:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
  logic filt_en, swing_sel;
  logic [2:0] emph_lvl;
  vls_pkg::vls_state_t state_q, state_d;
  logic [7:0] idle_q, idle_d;
  logic [2:0] lock_q, lock_d;
  logic [15:0] lfsr_q, lfsr_d;
  logic [1:0] slot_q, slot_d;
  logic signed [7:0] disp_q, disp_d;
  logic [27:0] frame_q, frame_d;
  logic [4:0] bits_q, bits_d;
  logic ser_p_q, ser_p_d, ser_n_q, ser_n_d;
  logic swing_q, swing_d;
  logic [2:0] emph_q, emph_d;
  logic stopped, cur_bit, send;
  logic [2:0] ctl_q, ctl_d;
  logic [1:0] fcnt_q [3];
  logic [1:0] fcnt_d [3];
  logic [23:0] scr, bal, shuf;
  logic inv;
  logic signed [7:0] wdisp;

  // Power down clears all but the pixel clock synchronizer, registers included
  assign clr = reset | ~link.power_down_bar; // [R11]

  // Pixel clock pin: three stages, a level counts once stages 2 and 3 agree
  always_comb begin
    pclk_s_d = {pclk_s_q[1:0], link.pclk};
    pclk_lvl_d = pclk_lvl_q;
    if (pclk_s_q[1] == pclk_s_q[2]) begin
      pclk_lvl_d = pclk_s_q[2];
    end
  end
  // Edge tracking follows any spread-spectrum wander of the pixel clock
  assign rise = pclk_lvl_d & ~pclk_lvl_q; // [R7]

  always_ff @(posedge mclk) begin
    if (reset) begin
      pclk_s_q <= 3'h0;
      pclk_lvl_q <= 1'b0;
    end else begin
      pclk_s_q <= pclk_s_d;
      pclk_lvl_q <= pclk_lvl_d;
    end
  end

  // Control register write and read-back, status reflects link state
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = 8'h00;
    if (reg_wr && reg_addr == vls_pkg::REG_CTRL) begin
      ctrl_d = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        vls_pkg::REG_CTRL: rdata_d = ctrl_q;
        vls_pkg::REG_STAT: begin
          rdata_d[vls_pkg::STAT_SLEEP] = (state_q == vls_pkg::ST_SLEEP);
          rdata_d[vls_pkg::STAT_RUN] = (state_q == vls_pkg::ST_RUN);
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Only power down or reset clears the registers; sleep leaves them
  always_ff @(posedge mclk) begin
    if (clr) begin
      ctrl_q <= vls_pkg::CTRL_RESET; // [R11]
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d; // [R15]
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // Pin or register source for filter, swing and emphasis
  assign filt_en = ctrl_q[vls_pkg::CTRL_FILT_SRC] ? ctrl_q[vls_pkg::CTRL_FILT]
    : (link.compat_mode == vls_pkg::MODE_FILT_ON); // [R16]
  assign swing_sel = ctrl_q[vls_pkg::CTRL_SWING_SRC]
    ? ctrl_q[vls_pkg::CTRL_SWING] : link.output_swing_select; // [R8]
  assign emph_lvl = ctrl_q[vls_pkg::CTRL_EMPH_SRC]
    ? ctrl_q[vls_pkg::CTRL_EMPH_LSB +: 3] : link.tx_emphasis_level; // [R9]

  // Control filter: a new level must persist for three pixel clocks
  for (genvar i = 0; i < vls_pkg::CTL_W; i++) begin : g_filt
    logic raw;
    assign raw = link.pword[vls_pkg::BIT_HS + i]; // [R1]
    always_comb begin
      ctl_d[i] = ctl_q[i];
      fcnt_d[i] = fcnt_q[i];
      if (rise) begin
        if (!filt_en) begin
          ctl_d[i] = raw; // [R3]
          fcnt_d[i] = 2'h0;
        end else if (raw == ctl_q[i]) begin
          fcnt_d[i] = 2'h0; // [R5]
        end else if (fcnt_q[i] == FILT_LAST) begin
          ctl_d[i] = raw; // [R20] [R2] [R4]
          fcnt_d[i] = 2'h0;
        end else begin
          fcnt_d[i] = fcnt_q[i] + 2'h1;
        end
      end
    end
    always_ff @(posedge mclk) begin
      if (clr) begin
        ctl_q[i] <= 1'b0;
        fcnt_q[i] <= 2'h0;
      end else begin
        ctl_q[i] <= ctl_d[i];
        fcnt_q[i] <= fcnt_d[i];
      end
    end
  end

  // Scramble the 24 data bits, bit 27 of the word is never looked at
  assign scr = link.pword[vls_pkg::DATA_W-1:0]
    ^ vls_pkg::scr_key(lfsr_q); // [R6] [R18] [R19]

  // Balance: invert when the word would push disparity further out
  always_comb begin
    int ones;
    ones = 0;
    for (int k = 0; k < vls_pkg::DATA_W; k++) begin
      ones = ones + int'(scr[k]);
    end
    wdisp = $signed(8'(2 * ones)) - 8'sh18;
    inv = (disp_q >= 8'sh00) ? (wdisp > 8'sh00) : (wdisp < 8'sh00); // [R19]
  end
  assign bal = inv ? ~scr : scr; // [R6]

  // Shuffle: output position i takes balanced bit (i*7) mod 24
  for (genvar i = 0; i < vls_pkg::DATA_W; i++) begin : g_shuf
    assign shuf[i] = bal[(i * vls_pkg::SHUF_MUL) % vls_pkg::DATA_W]; // [R6]
  end

  assign stopped = (idle_q >= STOP_CNT);
  assign cur_bit = (bits_q != 5'h00) ? frame_q[0] : 1'b0;
  assign send = (state_q == vls_pkg::ST_RUN) && rise && (bits_q == 5'h00);

  // Sleep, lock and run sequencing, frame build and bit shifting
  always_comb begin
    state_d = state_q;
    lock_d = lock_q;
    idle_d = rise ? 8'h00 : (stopped ? idle_q : idle_q + 8'h01);
    lfsr_d = lfsr_q;
    slot_d = slot_q;
    disp_d = disp_q;
    frame_d = frame_q >> 1;
    bits_d = (bits_q != 5'h00) ? bits_q - 5'h01 : 5'h00;
    case (state_q)
      vls_pkg::ST_SLEEP: begin
        if (rise) begin
          state_d = vls_pkg::ST_LOCK;
          lock_d = 3'h1;
        end
      end
      vls_pkg::ST_LOCK: begin
        if (stopped) begin
          state_d = vls_pkg::ST_SLEEP; // [R12]
        end else if (rise) begin
          if (lock_q == LOCK_LAST) begin
            state_d = vls_pkg::ST_RUN; // [R14]
          end else begin
            lock_d = lock_q + 3'h1;
          end
        end
      end
      vls_pkg::ST_RUN: begin
        if (stopped) begin
          state_d = vls_pkg::ST_SLEEP; // [R12]
        end
      end
      default: state_d = vls_pkg::ST_SLEEP;
    endcase
    if (state_q != vls_pkg::ST_RUN) begin
      lfsr_d = vls_pkg::LFSR_SEED; // [R19]
      slot_d = 2'h0;
      disp_d = 8'sh00;
    end else if (send) begin
      frame_d[vls_pkg::FR_CLK_HI] = 1'b1; // [R17]
      frame_d[vls_pkg::FR_CLK_LO] = 1'b0;
      frame_d[vls_pkg::FR_DATA +: vls_pkg::DATA_W] = shuf;
      frame_d[vls_pkg::FR_CHECK] = ctl_q[slot_q];
      frame_d[vls_pkg::FR_BAL] = inv;
      bits_d = FRAME_BITS;
      lfsr_d = vls_pkg::lfsr_next(lfsr_q);
      slot_d = (slot_q == 2'h2) ? 2'h0 : slot_q + 2'h1;
      disp_d = inv ? disp_q - wdisp : disp_q + wdisp;
    end
    ser_p_d = cur_bit;
    ser_n_d = ~cur_bit;
    swing_d = swing_sel; // [R8]
    emph_d = vls_pkg::EMPH_OFF;
    if (bits_q != 5'h00 && cur_bit == ser_p_q) begin
      emph_d = emph_lvl; // [R9]
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      state_q <= vls_pkg::ST_SLEEP;
      lock_q <= 3'h0;
      idle_q <= 8'h00;
      lfsr_q <= vls_pkg::LFSR_SEED;
      slot_q <= 2'h0;
      disp_q <= 8'sh00;
      frame_q <= 28'h0000000;
      bits_q <= 5'h00;
      ser_p_q <= 1'b1; // [R11]
      ser_n_q <= 1'b1;
      swing_q <= 1'b0;
      emph_q <= vls_pkg::EMPH_OFF;
    end else begin
      state_q <= state_d;
      lock_q <= lock_d;
      idle_q <= idle_d;
      lfsr_q <= lfsr_d;
      slot_q <= slot_d;
      disp_q <= disp_d;
      frame_q <= frame_d;
      bits_q <= bits_d;
      ser_p_q <= ser_p_d;
      ser_n_q <= ser_n_d;
      swing_q <= swing_d;
      emph_q <= emph_d;
    end
  end

  assign link.serial_p = ser_p_q;
  assign link.serial_n = ser_n_q;
  assign link.swing_high = swing_q;
  assign link.emph_now = emph_q;
endmodule : vls_serializer

//--- verilog/vls_partner.sv
// Partner end: host pixel source plus the receiving deserializer
module vls_partner (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Link pins
  vls_link_if.host link,
  // Source side
  input wire logic [26:0] src_word,
  input wire logic clock_run,
  input wire logic power_on,
  input wire logic [1:0] cfg_mode,
  input wire logic swing_sel,
  input wire logic [2:0] emph_level,
  output logic src_taken,
  // Receive side
  output logic [23:0] rx_data,
  output logic [2:0] rx_ctl,
  output logic rx_valid,
  output logic rx_locked
);
  localparam logic [4:0] DIV_LAST = 5'(vls_pkg::PCLK_DIV - 1);
  localparam logic [4:0] HALF = 5'(vls_pkg::PCLK_HALF);
  localparam logic [4:0] LAST_BIT = 5'(vls_pkg::FRAME_W - 1);
  localparam logic [6:0] GAP = 7'(vls_pkg::GAP_CYC);

  logic [4:0] div_q, div_d;
  logic pclk_q, pclk_d, taken_q, taken_d, pdb_q, swing_q;
  logic [27:0] word_q, word_d;
  logic [1:0] cfg_q;
  logic [2:0] emph_q;
  logic [4:0] rxc_q, rxc_d;
  logic [27:0] sh_q, sh_d;
  logic done_q, done_d;
  logic [6:0] gap_q, gap_d;
  logic [15:0] lfsr_q, lfsr_d;
  logic [1:0] slot_q, slot_d;
  logic [23:0] data_q, data_d, bal;
  logic [2:0] ctl_q, ctl_d;
  logic valid_q, valid_d, lock_q, lock_d, line;

  // Pixel clock divider; a stopped clock parks in its low phase
  always_comb begin
    div_d = (div_q == DIV_LAST) ? 5'h00 : div_q + 5'h01;
    if (!clock_run && div_q == HALF) begin
      div_d = div_q; // [R13]
    end
    pclk_d = (div_d < HALF);
    word_d = word_q;
    taken_d = 1'b0;
    if (div_q == HALF - 5'h01) begin
      word_d = {1'b0, src_word}; // [R18] [R1]
      taken_d = 1'b1;
    end
  end

  // Pins toward the serializer, emphasis forces the high swing
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_q <= 5'h00;
      pclk_q <= 1'b0;
      word_q <= 28'h0000000;
      taken_q <= 1'b0;
      pdb_q <= 1'b0;
      cfg_q <= vls_pkg::MODE_FILT_OFF;
      swing_q <= 1'b0;
      emph_q <= vls_pkg::EMPH_OFF;
    end else begin
      div_q <= div_d;
      pclk_q <= pclk_d;
      word_q <= word_d;
      taken_q <= taken_d;
      pdb_q <= power_on;
      cfg_q <= cfg_mode; // [R16]
      swing_q <= swing_sel | (emph_level != vls_pkg::EMPH_OFF); // [R10]
      emph_q <= emph_level;
    end
  end

  assign link.pclk = pclk_q;
  assign link.pword = word_q;
  assign link.power_down_bar = pdb_q;
  assign link.compat_mode = cfg_q;
  assign link.output_swing_select = swing_q;
  assign link.tx_emphasis_level = emph_q;
  assign src_taken = taken_q;
  assign line = link.serial_p;

  // Undo the shuffle: balanced bit (i*7) mod 24 sits at position i
  for (genvar i = 0; i < vls_pkg::DATA_W; i++) begin : g_unshuf
    assign bal[(i * vls_pkg::SHUF_MUL) % vls_pkg::DATA_W] =
      sh_q[vls_pkg::FR_DATA + i] ^ sh_q[vls_pkg::FR_BAL]; // [R19]
  end

  // Frame capture, long idle resynchronises the descrambler
  always_comb begin
    rxc_d = rxc_q;
    sh_d = sh_q;
    done_d = 1'b0;
    gap_d = gap_q;
    lfsr_d = lfsr_q;
    slot_d = slot_q;
    data_d = data_q;
    ctl_d = ctl_q;
    valid_d = 1'b0;
    lock_d = lock_q;
    if (rxc_q != 5'h00 || line) begin
      sh_d = {line, sh_q[27:1]};
      gap_d = 7'h00;
      rxc_d = (rxc_q == LAST_BIT) ? 5'h00 : rxc_q + 5'h01;
      done_d = (rxc_q == LAST_BIT);
    end else if (gap_q == GAP) begin
      lfsr_d = vls_pkg::LFSR_SEED;
      slot_d = 2'h0;
      lock_d = 1'b0;
    end else begin
      gap_d = gap_q + 7'h01;
    end
    if (done_q && sh_q[vls_pkg::FR_CLK_HI] && !sh_q[vls_pkg::FR_CLK_LO]) begin
      data_d = bal ^ vls_pkg::scr_key(lfsr_q); // [R17] [R6]
      ctl_d[slot_q] = sh_q[vls_pkg::FR_CHECK];
      lfsr_d = vls_pkg::lfsr_next(lfsr_q);
      slot_d = (slot_q == 2'h2) ? 2'h0 : slot_q + 2'h1;
      valid_d = 1'b1;
      lock_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rxc_q <= 5'h00;
      sh_q <= 28'h0000000;
      done_q <= 1'b0;
      gap_q <= 7'h00;
      lfsr_q <= vls_pkg::LFSR_SEED;
      slot_q <= 2'h0;
      data_q <= 24'h000000;
      ctl_q <= 3'h0;
      valid_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      rxc_q <= rxc_d;
      sh_q <= sh_d;
      done_q <= done_d;
      gap_q <= gap_d;
      lfsr_q <= lfsr_d;
      slot_q <= slot_d;
      data_q <= data_d;
      ctl_q <= ctl_d;
      valid_q <= valid_d;
      lock_q <= lock_d;
    end
  end

  assign rx_data = data_q;
  assign rx_ctl = ctl_q;
  assign rx_valid = valid_q;
  assign rx_locked = lock_q;
endmodule : vls_partner

//--- tb/vls_link_asserts.sv
// Concurrent checks on the link between serializer and partner end
module vls_link_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Link signals
  input wire logic pclk,
  input wire logic [vls_pkg::WORD_W-1:0] pword,
  input wire logic power_down_bar,
  input wire logic output_swing_select,
  input wire logic [2:0] tx_emphasis_level,
  input wire logic serial_p,
  input wire logic serial_n,
  input wire logic swing_high,
  input wire logic [2:0] emph_now
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] fcnt_q, fcnt_d, since_q, since_d;
  logic [1:0] pdh_q, pdh_d;
  logic pclk_q, fstart, up3, dn3;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Frame start seen on an idle line, power held steady for three samples
  assign fstart = fcnt_q == 5'h00 && serial_p && !serial_n;
  assign up3 = power_down_bar && pdh_q == 2'h3;
  assign dn3 = !power_down_bar && pdh_q == 2'h0;

  // Bit position in a frame and cycles since the last pixel clock rise
  always_comb begin
    pdh_d = {pdh_q[0], power_down_bar};
    since_d = since_q + {4'h0, since_q != 5'h1F};
    if (pclk && !pclk_q) since_d = 5'h00;
    fcnt_d = fcnt_q + 5'h01;
    if (fcnt_q == 5'h00 || fcnt_q == 5'h1C) fcnt_d = 5'h00;
    if (fstart) fcnt_d = 5'h01;
    if (reset || !power_down_bar) fcnt_d = 5'h00;
    if (reset) since_d = 5'h1F;
  end

  // Helper registers
  always_ff @(posedge mclk) begin
    pdh_q <= pdh_d;
    since_q <= since_d;
    fcnt_q <= fcnt_d;
    pclk_q <= pclk;
  end

  pd_lines_a: assert property (
    dn3 |-> serial_p && serial_n && emph_now == 3'h0 && !swing_high)
    else $error("power down left the line driven");
  line_diff_a: assert property (
    up3 |-> serial_n == !serial_p)
    else $error("serial pair not complementary");
  clk_bits_a: assert property (
    fcnt_q == 5'h01 |-> !serial_p && serial_n)
    else $error("second frame bit not low");
  frame_gap_a: assert property (
    fcnt_q == 5'h1C |-> !serial_p)
    else $error("line not idle after a frame");
  frame_rise_a: assert property (
    fstart |-> since_q <= 5'h0C)
    else $error("frame sent without a recent pixel clock rise");
  emph_edge_a: assert property (
    emph_now != 3'h0 |-> serial_p == $past(serial_p))
    else $error("emphasis applied on a transition bit");
  emph_level_a: assert property (
    $stable(tx_emphasis_level) [*3] ##0 emph_now != 3'h0
      |-> emph_now == tx_emphasis_level)
    else $error("emphasis level differs from setting");
  swing_pin_a: assert property (
    $stable(output_swing_select) [*3] ##0 up3
      |-> swing_high == output_swing_select)
    else $error("swing level differs from select");
  emph_swing_a: assert property (
    tx_emphasis_level != 3'h0 |-> output_swing_select)
    else $error("emphasis used with standard swing");
  top_bit_a: assert property (
    !pword[vls_pkg::BIT_UNUSED])
    else $error("unused word bit driven high");
endmodule : vls_link_asserts

//--- tb/test_video_link_serializer_ctrl.sv
// Self-checking bench joining the serializer and its partner end
module test_video_link_serializer_ctrl;
  timeunit 1ns;
  timeprecision 100ps;

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

  localparam logic [26:0] WORDS [4] = '{27'h1000000, 27'h2FFFFFF,
    27'h45A5A5A, 27'h7123456};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [26:0] src_word = 27'h0;
  logic clock_run = 1'b0;
  logic power_on = 1'b0;
  logic [1:0] cfg_mode = 2'h0;
  logic swing_sel = 1'b0;
  logic [2:0] emph_level = 3'h0;
  logic src_taken, rx_valid, rx_locked;
  logic [23:0] rx_data;
  logic [2:0] rx_ctl;
  int miscompares = 0;
  int checks = 0;
  int vld_cnt = 0;
  int de_cnt = 0;
  int em_cnt = 0;
  int base;

  vls_link_if vls_link_if_i ();
  vls_serializer vls_serializer_i (.mclk(mclk), .reset(reset),
    .link(vls_link_if_i), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  vls_partner vls_partner_i (.mclk(mclk), .reset(reset),
    .link(vls_link_if_i), .src_word(src_word), .clock_run(clock_run),
    .power_on(power_on), .cfg_mode(cfg_mode), .swing_sel(swing_sel),
    .emph_level(emph_level), .src_taken(src_taken), .rx_data(rx_data),
    .rx_ctl(rx_ctl), .rx_valid(rx_valid), .rx_locked(rx_locked));
  vls_link_asserts vls_link_asserts_i (.mclk(mclk), .reset(reset),
    .pclk(vls_link_if_i.pclk), .pword(vls_link_if_i.pword),
    .power_down_bar(vls_link_if_i.power_down_bar),
    .output_swing_select(vls_link_if_i.output_swing_select),
    .tx_emphasis_level(vls_link_if_i.tx_emphasis_level),
    .serial_p(vls_link_if_i.serial_p), .serial_n(vls_link_if_i.serial_n),
    .swing_high(vls_link_if_i.swing_high),
    .emph_now(vls_link_if_i.emph_now));

  // Clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  // Counts received frames, frames with data enable set, emphasised bits
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) vld_cnt++;
    if (rx_valid === 1'b1 && rx_ctl[2] === 1'b1) de_cnt++;
    if (vls_link_if_i.emph_now !== 3'h0) em_cnt++;
  end

  // Prints the counts and the verdict, then stops
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Register write and read with expected value
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd

  // Waits for n source samples, bounded
  task automatic frames(input int n);
    int k = 0;
    for (int i = 0; i < 64 * n && k < n; i++) begin
      @(posedge mclk);
      #1;
      if (src_taken === 1'b1) k++;
    end
    if (k != n) begin
      miscompares++;
      results();
    end
  endtask : frames
  task automatic setw(input logic [26:0] w, input int n);
    @(posedge mclk);
    src_word <= w;
    frames(n);
  endtask : setw

  // Main sequence
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    power_on <= 1'b1;
    clock_run <= 1'b1;
    frames(8);
    rd(vls_pkg::REG_STAT, 8'h02);
    rd(vls_pkg::REG_CTRL, vls_pkg::CTRL_RESET);
    wr(vls_pkg::REG_CTRL, 8'h41);
    rd(vls_pkg::REG_CTRL, 8'h41);
    wr(vls_pkg::REG_STAT, 8'hFF);
    rd(vls_pkg::REG_STAT, 8'h02);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      setw(WORDS[i], 10);
      `CHK(rx_data, WORDS[i][23:0])
      `CHK(rx_ctl, WORDS[i][26:24])
    end
    `CHK(rx_locked, 1'b1)
    $display("pixel data done");
    // Short data enable pulse: off by pins, on by pins, on by register
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk);
      cfg_mode <= (m == 1) ? vls_pkg::MODE_FILT_ON : vls_pkg::MODE_FILT_OFF;
      wr(vls_pkg::REG_CTRL, (m == 2) ? 8'h0C : 8'h00);
      setw(27'h0, 10);
      base = de_cnt;
      for (int r = 0; r < 3; r++) begin
        setw(27'h4000000, 2);
        setw(27'h0, 131);
      end
      `CHK(de_cnt != base, m == 0)
    end
    $display("control filter done");
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      emph_level <= (i < 5) ? 3'(i) : 3'h0;
      swing_sel <= (i == 5);
      frames(1);
      base = em_cnt;
      frames(2);
      `CHK(vls_link_if_i.swing_high, i != 0)
      `CHK(em_cnt != base, i > 0 && i < 5)
    end
    $display("driver settings done");
    wr(vls_pkg::REG_CTRL, 8'h41);
    @(posedge mclk);
    clock_run <= 1'b0;
    repeat (150) @(posedge mclk);
    rd(vls_pkg::REG_STAT, 8'h01);
    rd(vls_pkg::REG_CTRL, 8'h41);
    @(posedge mclk);
    clock_run <= 1'b1;
    base = vld_cnt;
    repeat (96) @(posedge mclk);
    `CHK(vld_cnt == base, 1'b1)
    frames(6);
    rd(vls_pkg::REG_STAT, 8'h02);
    `CHK(vld_cnt != base, 1'b1)
    $display("stop clock done");
    @(posedge mclk);
    power_on <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    `CHK({vls_link_if_i.serial_p, vls_link_if_i.serial_n}, 2'h3)
    rd(vls_pkg::REG_CTRL, 8'h00);
    @(posedge mclk);
    power_on <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(vls_pkg::REG_CTRL, vls_pkg::CTRL_RESET);
    $display("power down done");
    results();
  end
endmodule : test_video_link_serializer_ctrl
